// ---- verilog/jtbs_defs.vh ----
// constants for the boundary scan test logic: instructions, chain layout, enable cells
//
// Functional notes
// - one-bit bypass stage links tdi to tdo when no other register selected
// - at reset the test logic resets and holds the bypass instruction
// - scan cells sit on host bus, boot rom and media pins, not network ports
// - enable cells hold pad enables; when one during extest, pins drive cell data
// - one enable for address/data, one for command lanes, separate control enables
// - four boot rom data enables, plus media, mode and serial-out enables
// - chain runs boot rom, mode and serial cells, host bus, then request..interrupt
// - full tap state machine generates capture, shift and update controls
// - three-bit instruction; 000 extest, 001 sample, 101 float, 110 continuity, 111 bypass
// - under bypass the test logic never touches normal system behaviour
// - tristate instruction floats every pad and freezes internal clocks
`ifndef JTBS_DEFS_VH
`define JTBS_DEFS_VH

`define JTBS_IR_W 3
`define JTBS_IR_EXTEST 3'h0
`define JTBS_IR_SAMPLE 3'h1
`define JTBS_IR_TRISTATE 3'h5
`define JTBS_IR_CONTINUITY 3'h6
`define JTBS_IR_BYPASS 3'h7
`define JTBS_IR_CAPTURE 3'h1

// chain length and cell index 0 is nearest tdi
`define JTBS_CHAIN_LEN 78
// cells that hold drive enables rather than pin levels
`define JTBS_EN_MASK 78'h00000015752000025445
// output cells with no enable cell, driven whenever extest is active
`define JTBS_DRV_MASK 78'h22000000008000010000

// enable cell positions
`define JTBS_BR02_OE 0
`define JTBS_BR13_OE 2
`define JTBS_BR64_OE 6
`define JTBS_BR7_OE 10
`define JTBS_MEDIA_OE 12
`define JTBS_MODE_OE 14
`define JTBS_SDO_OE 17
`define JTBS_PAR_OE 37
`define JTBS_PERR_OE 40
`define JTBS_STOP_OE 42
`define JTBS_AD_OE 44
`define JTBS_CBE_OE 45
`define JTBS_DEVSEL_OE 46
`define JTBS_TRDY_OE 48
`define JTBS_IRDY_OE 50
`define JTBS_FRAME_OE 52

// first cell of each address/data byte lane and the command lane cells
`define JTBS_AD0_IDX 19
`define JTBS_AD8_IDX 28
`define JTBS_AD16_IDX 55
`define JTBS_AD24_IDX 65
`define JTBS_CBE0_IDX 27
`define JTBS_CBE1_IDX 36
`define JTBS_CBE2_IDX 54
`define JTBS_CBE3_IDX 64

`endif

// ---- verilog/jtbs_sync.v ----
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module jtbs_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule
`default_nettype wire

// ---- verilog/jtbs_tap.v ----
// tap controller, instruction, bypass and boundary scan registers with pad muxing
`timescale 1ns/1ns
`default_nettype none
`include "jtbs_defs.vh"

module jtbs_tap (
    input wire clk,
    input wire sys_rst,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    input wire [`JTBS_CHAIN_LEN-1:0] core_out,
    input wire [`JTBS_CHAIN_LEN-1:0] core_oe,
    input wire [`JTBS_CHAIN_LEN-1:0] pad_in,
    output reg [`JTBS_CHAIN_LEN-1:0] pad_out,
    output reg [`JTBS_CHAIN_LEN-1:0] pad_oe,
    output reg clk_freeze
);

    localparam L = `JTBS_CHAIN_LEN;

    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_SEL_DR = 4'h2;
    localparam [3:0] ST_CAP_DR = 4'h3;
    localparam [3:0] ST_SHIFT_DR = 4'h4;
    localparam [3:0] ST_EX1_DR = 4'h5;
    localparam [3:0] ST_PAUSE_DR = 4'h6;
    localparam [3:0] ST_EX2_DR = 4'h7;
    localparam [3:0] ST_UPD_DR = 4'h8;
    localparam [3:0] ST_SEL_IR = 4'h9;
    localparam [3:0] ST_CAP_IR = 4'hA;
    localparam [3:0] ST_SHIFT_IR = 4'hB;
    localparam [3:0] ST_EX1_IR = 4'hC;
    localparam [3:0] ST_PAUSE_IR = 4'hD;
    localparam [3:0] ST_EX2_IR = 4'hE;
    localparam [3:0] ST_UPD_IR = 4'hF;

    // enable cell that governs a data cell, -1 where none
    function integer en_of;
        input integer i;
        begin
            en_of = -1;
            if ((i >= `JTBS_AD0_IDX && i < `JTBS_AD0_IDX + 8) ||
                (i >= `JTBS_AD8_IDX && i < `JTBS_AD8_IDX + 8) ||
                (i >= `JTBS_AD16_IDX && i < `JTBS_AD16_IDX + 8) ||
                (i >= `JTBS_AD24_IDX && i < `JTBS_AD24_IDX + 8))
                en_of = `JTBS_AD_OE;
            else if (i == `JTBS_CBE0_IDX || i == `JTBS_CBE1_IDX ||
                     i == `JTBS_CBE2_IDX || i == `JTBS_CBE3_IDX)
                en_of = `JTBS_CBE_OE;
            else if (i == `JTBS_BR02_OE + 1 || i == `JTBS_BR02_OE + 4)
                en_of = `JTBS_BR02_OE;
            else if (i == `JTBS_BR13_OE + 1 || i == `JTBS_BR13_OE + 3)
                en_of = `JTBS_BR13_OE;
            else if (i > `JTBS_BR64_OE && i <= `JTBS_BR64_OE + 3)
                en_of = `JTBS_BR64_OE;
            else if (i == `JTBS_BR7_OE + 1)
                en_of = `JTBS_BR7_OE;
            else if (i == `JTBS_MEDIA_OE + 1)
                en_of = `JTBS_MEDIA_OE;
            else if (i == `JTBS_MODE_OE + 1)
                en_of = `JTBS_MODE_OE;
            else if (i == `JTBS_SDO_OE + 1)
                en_of = `JTBS_SDO_OE;
            else if (i == `JTBS_PAR_OE + 1)
                en_of = `JTBS_PAR_OE;
            else if (i == `JTBS_PERR_OE + 1)
                en_of = `JTBS_PERR_OE;
            else if (i == `JTBS_STOP_OE + 1)
                en_of = `JTBS_STOP_OE;
            else if (i == `JTBS_DEVSEL_OE + 1)
                en_of = `JTBS_DEVSEL_OE;
            else if (i == `JTBS_TRDY_OE + 1)
                en_of = `JTBS_TRDY_OE;
            else if (i == `JTBS_IRDY_OE + 1)
                en_of = `JTBS_IRDY_OE;
            else if (i == `JTBS_FRAME_OE + 1)
                en_of = `JTBS_FRAME_OE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and test clock edge detection

    wire [2:0] link_s;
    wire [L-1:0] pad_s;
    reg tck_d_r;

    jtbs_sync #(.WIDTH(3)) u_link_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({tck, tms, tdi}),
        .q(link_s)
    );

    jtbs_sync #(.WIDTH(L)) u_pad_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pad_in),
        .q(pad_s)
    );

    wire tck_s = link_s[2];
    wire tms_s = link_s[1];
    wire tdi_s = link_s[0];

    // edges are seen in the same clk the second stage shows them, so tck must stay above 3 clk per phase
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    wire tck_rise = tck_s & ~tck_d_r;
    wire tck_fall = ~tck_s & tck_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // tap state machine

    reg [3:0] state_r;
    reg [3:0] state_nxt;

    // standard sixteen-state walk steered by tms
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: state_nxt = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = tms_s ? ST_EX1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_nxt = tms_s ? ST_EX1_DR : ST_SHIFT_DR;
            ST_EX1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_nxt = tms_s ? ST_EX2_DR : ST_PAUSE_DR;
            ST_EX2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_nxt = tms_s ? ST_EX1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_nxt = tms_s ? ST_EX1_IR : ST_SHIFT_IR;
            ST_EX1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_nxt = tms_s ? ST_EX2_IR : ST_PAUSE_IR;
            ST_EX2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
            default: state_nxt = ST_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction, bypass and boundary registers

    reg [`JTBS_IR_W-1:0] ir_r;
    reg [`JTBS_IR_W-1:0] ir_sh_r;
    reg byp_r;
    reg [L-1:0] bsr_sh_r;
    reg [L-1:0] bsr_upd_r;

    // reserved codes and tristate fall back to the bypass stage
    wire bsr_sel = (ir_r == `JTBS_IR_EXTEST) || (ir_r == `JTBS_IR_SAMPLE) ||
                   (ir_r == `JTBS_IR_CONTINUITY);
    wire [L-1:0] en_mask = `JTBS_EN_MASK;
    wire [L-1:0] drv_mask = `JTBS_DRV_MASK;
    // enable cells capture core_out at their own position, pin cells the pin level
    wire [L-1:0] cap_vec = (core_out & en_mask) | (pad_s & ~en_mask);

    // all register actions happen on the rising test clock event
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_RESET;
            ir_r <= `JTBS_IR_BYPASS;
            ir_sh_r <= `JTBS_IR_CAPTURE;
            byp_r <= 1'b0;
            bsr_sh_r <= {L{1'b0}};
            bsr_upd_r <= {L{1'b0}};
        end else if (tck_rise) begin
            state_r <= state_nxt;
            case (state_r)
                ST_RESET: ir_r <= `JTBS_IR_BYPASS;
                ST_CAP_IR: ir_sh_r <= `JTBS_IR_CAPTURE;
                ST_SHIFT_IR: ir_sh_r <= {tdi_s, ir_sh_r[`JTBS_IR_W-1:1]};
                ST_UPD_IR: ir_r <= ir_sh_r;
                ST_CAP_DR: begin
                    if (bsr_sel)
                        bsr_sh_r <= cap_vec;
                    else
                        byp_r <= 1'b0;
                end
                ST_SHIFT_DR: begin
                    if (bsr_sel)
                        bsr_sh_r <= {bsr_sh_r[L-2:0], tdi_s};
                    else
                        byp_r <= tdi_s;
                end
                ST_UPD_DR: begin
                    if (bsr_sel)
                        bsr_upd_r <= bsr_sh_r;
                end
                default: ir_r <= ir_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial output, changed on the falling test clock event

    wire shift_ir = (state_r == ST_SHIFT_IR);
    wire shift_dr = (state_r == ST_SHIFT_DR);
    wire ser_bit = shift_ir ? ir_sh_r[0] : (bsr_sel ? bsr_sh_r[L-1] : byp_r);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= ser_bit;
            tdo_oe <= shift_ir | shift_dr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad muxing per cell; cells exist only on host bus, boot rom and media pins

    wire extest = (ir_r == `JTBS_IR_EXTEST);
    wire tristate = (ir_r == `JTBS_IR_TRISTATE);

    // network clocks keep running; only core clocks are frozen
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_freeze <= 1'b0;
        end else begin
            clk_freeze <= tristate;
        end
    end

    wire [L-1:0] ext_oe;

    // per cell extest drive enable: its enable cell, or the drv_mask bit where none exists
    genvar gi;
    generate
        for (gi = 0; gi < L; gi = gi + 1) begin : g_cell
            localparam integer EN = en_of(gi);
            localparam integer ENX = (EN < 0) ? 0 : EN;
            assign ext_oe[gi] = (EN >= 0) ? bsr_upd_r[ENX] : drv_mask[gi];
        end
    endgenerate

    // outside extest and tristate the core owns the pad untouched
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pad_out <= {L{1'b0}};
            pad_oe <= {L{1'b0}};
        end else if (tristate) begin
            pad_out <= core_out;
            pad_oe <= {L{1'b0}};
        end else if (extest) begin
            pad_out <= bsr_upd_r;
            pad_oe <= ext_oe;
        end else begin
            pad_out <= core_out;
            pad_oe <= core_oe;
        end
    end

endmodule
`default_nettype wire

// ---- testbench/jtbs_tap_monitor.sv ----
// assertion checker for the boundary scan tap ports
`timescale 1ns/1ns
`default_nettype none
module jtbs_tap_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [77:0] core_out,
    input wire logic [77:0] core_oe,
    input wire logic [77:0] pad_out,
    input wire logic [77:0] pad_oe,
    input wire logic clk_freeze
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // clocks since the test clock pin last moved; pads settle well inside 8
    logic tck_r;
    logic [3:0] quiet_r;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tck_r <= 1'b0;
            quiet_r <= 4'h0;
        end else begin
            tck_r <= tck;
            quiet_r <= (tck != tck_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
        end
    end
    ////////////////////////////////////////
    a_reset_state: assert property ($past(sys_rst) |-> !tdo && !tdo_oe && !clk_freeze)
        else $error("outputs not quiet after reset");
    a_tdo_fall_edge: assert property (!$stable(tdo) |-> !$past(tck, 2))
        else $error("tdo moved outside a low test clock phase");
    a_oe_fall_edge: assert property (!$stable(tdo_oe) |-> !$past(tck, 2))
        else $error("tdo enable moved outside a low test clock phase");
    a_oe_rise_hold: assert property ($rose(tdo_oe) |-> tdo_oe [*6])
        else $error("tdo enable dropped within one test clock");
    a_oe_fall_hold: assert property ($fell(tdo_oe) |-> !tdo_oe [*6])
        else $error("tdo enable returned within one test clock");
    a_float_all_pads: assert property (clk_freeze && $past(clk_freeze) |-> pad_oe == '0)
        else $error("a pad drives while frozen");
    a_freeze_at_rise: assert property (!$stable(clk_freeze) |-> $past(tck, 2))
        else $error("freeze changed away from a test clock rise");
    a_pads_settle: assert property (quiet_r >= 4'h8 && $past(core_out) == $past(core_out, 2)
        && $past(core_oe) == $past(core_oe, 2) |-> $stable(pad_out) && $stable(pad_oe))
        else $error("pads moved with no cause");
    c_freeze: cover property ($rose(clk_freeze));
    c_shift: cover property ($rose(tdo_oe));
    c_settle: cover property (quiet_r == 4'hF && pad_oe != '0);
endmodule

bind jtbs_tap jtbs_tap_monitor jtbs_tap_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .clk_freeze(clk_freeze));
`default_nettype wire

// ---- testbench/jtbs_ctl.sv ----
// board test controller model driving the test access port pins
`timescale 1ns/1ns
`default_nettype none
module jtbs_ctl (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // test clock stands low between frames; mode and data idle high like pull-ups
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // one test clock: inputs change with the fall, tdo is taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        o = tdo;
        repeat (4) @(negedge clk);
        tck = 1'b0;
    endtask

    // five ones reach test-logic-reset, then one zero parks in idle
    task automatic reset_tap();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask

    // scan n bits lsb first from idle, leaving via update back to idle
    task automatic scan(input logic ir, input logic [77:0] din, input int n,
        output logic [77:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

// ---- testbench/jtbs_tap_tb_top.sv ----
// self-checking bench for the boundary scan tap
`timescale 1ns/1ns
`default_nettype none
`include "jtbs_defs.vh"
module jtbs_tap_tb_top;
    localparam logic [77:0] EN = `JTBS_EN_MASK;
    localparam logic [77:0] DRV = `JTBS_DRV_MASK;
    typedef struct {int k; logic [77:0] e; logic [77:0] m;} jtbs_note_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, clk_freeze;
    logic [77:0] core_out = '0, core_oe = '0, pad_in = '0, pad_out, pad_oe, upd, got, d;
    integer seed = 32'hA9CE;
    int failures = 0;
    int tests_run = 0;
    jtbs_note_t exp_q[$];
    logic [77:0] got_q[$];

    // 20 MHz system clock
    always #25 clk = ~clk;

    jtbs_tap jtbs_tap_inst (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .clk_freeze(clk_freeze));
    jtbs_ctl jtbs_ctl_inst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    ////////////////////////////////////////
    function automatic logic [77:0] rnd();
        rnd = 78'({$random(seed), $random(seed), $random(seed)});
    endfunction

    // bit order reversal between cell index and shift order
    function automatic logic [77:0] rev(logic [77:0] v);
        for (int i = 0; i < 78; i++)
            rev[i] = v[77 - i];
    endfunction

    // enable cell gating each pin cell, -1 for none
    function automatic int en_of(int i);
        case (i)
            1, 4: return 0;
            3, 5: return 2;
            7, 8, 9: return 6;
            11: return 10;
            13: return 12;
            15: return 14;
            18: return 17;
            27, 36, 54, 64: return 45;
            38, 41, 43: return i - 1;
            47, 49, 51, 53: return i - 1;
            default: return (i inside {[19:35], [55:62], [65:72]}) ? 44 : -1;
        endcase
    endfunction

    // extest drive enables: free cells always, gated cells from their enable
    function automatic logic [77:0] exp_oe(logic [77:0] u);
        for (int i = 0; i < 78; i++)
            exp_oe[i] = DRV[i] | (en_of(i) >= 0 && u[en_of(i)]);
    endfunction

    task automatic note(int k, logic [77:0] e, logic [77:0] m, logic [77:0] g);
        exp_q.push_back(jtbs_note_t'{k, e, m});
        got_q.push_back(g);
    endtask

    task automatic chk_scan(jtbs_note_t n, logic [77:0] g);
        tests_run++;
        if ((g & n.m) !== (n.e & n.m)) begin
            failures++;
            $display("[ERR] %0t scan out %h exp %h", $time, g & n.m, n.e & n.m);
        end
    endtask

    task automatic chk_pads(jtbs_note_t n, logic [77:0] g);
        tests_run++;
        if ((g & n.m) !== (n.e & n.m)) begin
            failures++;
            $display("[ERR] %0t pads %h exp %h", $time, g & n.m, n.e & n.m);
        end
    endtask

    // oldest expectation against oldest observation
    always begin
        wait (got_q.size() > 0);
        if (exp_q[0].k == 0)
            chk_scan(exp_q.pop_front(), got_q.pop_front());
        else
            chk_pads(exp_q.pop_front(), got_q.pop_front());
    end
    ////////////////////////////////////////
    // bypass captures zero, then delays tdi by one stage
    // tdo_oe is taken after the first shift fall, then again back in idle
    task automatic bypass_chk();
        logic oe;
        d = rnd();
        fork
            jtbs_ctl_inst.scan(1'b0, d, 8, got);
            begin
                repeat (32) @(negedge clk);
                oe = tdo_oe;
            end
        join
        note(0, {d[76:0], 1'b0}, 78'hFF, got);
        note(0, 78'h2, 78'h3, {76'h0, oe, tdo_oe});
    endtask

    task automatic load_ir(logic [2:0] c);
        jtbs_ctl_inst.scan(1'b1, 78'(c), 3, got);
        note(0, 78'h1, 78'h7, got);
    endtask

    // long quiet wait so the settle check sees the test clock at rest
    task automatic pass_chk();
        core_out = rnd();
        core_oe = rnd();
        repeat (12) @(negedge clk);
        note(1, core_out, ~EN, pad_out);
        note(1, core_oe, ~EN, pad_oe);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence; all pin changes land on falling clock edges
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        pass_chk();
        jtbs_ctl_inst.step(1'b0, 1'b1, got[0]);
        bypass_chk();
        for (int c = 2; c < 8; c++) if (c != 6) begin
            load_ir(3'(c));
            note(1, 78'(c == 5), 78'h1, 78'(clk_freeze));
            if (c == 5) note(1, '0, '1, pad_oe);
            else pass_chk();
            bypass_chk();
        end
        for (int c = 1; c < 7; c += 5) begin
            load_ir(3'(c));
            pad_in = rnd();
            core_out = rnd();
            upd = rnd();
            jtbs_ctl_inst.scan(1'b0, rev(upd), 78, got);
            note(0, rev((pad_in & ~EN) | (core_out & EN)), '1, got);
            pass_chk();
        end
        load_ir(3'h0);
        note(1, upd, ~EN, pad_out);
        note(1, exp_oe(upd), '1, pad_oe);
        // a second reset in mid-run must drop extest and restore bypass
        sys_rst = 1'b1;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        pass_chk();
        jtbs_ctl_inst.step(1'b0, 1'b1, got[0]);
        bypass_chk();
        load_ir(3'h0);
        jtbs_ctl_inst.reset_tap();
        pass_chk();
        bypass_chk();
        wait (got_q.size() == 0);
        final_report();
    end

    // hang guard, far beyond the few hundred test clocks the run needs
    initial begin
        #2000000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
